// ### rtl/hevs_regs.vh
// Register offsets, field positions and reset values of the host event status block
`ifndef HEVS_REGS_VH
`define HEVS_REGS_VH
`define HEVS_STATUS_OFFSET 8'h0C
`define HEVS_ENABLE_OFFSET 8'h10
`define HEVS_STATUS_RESET 32'h00000000
`define HEVS_ENABLE_RESET 32'h00000000
`define HEVS_BIT_OVERRUN 0
`define HEVS_BIT_DONE_HEAD 1
`define HEVS_BIT_FRAME_START 2
`define HEVS_BIT_RESUME 3
`define HEVS_BIT_FATAL 4
`define HEVS_BIT_FRAME_OVF 5
`define HEVS_BIT_ROOT_HUB 6
`define HEVS_BIT_OWNER 30
`define HEVS_BIT_MASTER 31
`define HEVS_STATUS_MASK 32'h4000007F
`define HEVS_FRAME_MSB 15
`endif

// ### rtl/hevs_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module hevs_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Data
	input wire [WIDTH-1:0] d,
	output reg [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= {WIDTH{1'b0}};
			q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ### rtl/hevs_status.v
// Host event status register with enable, interrupt and system management request
// How it works
// - Each controller event sets its own sticky flag until software clears it.
// - Host interrupt requested when a flag in bits 0 to 6, its enable and master enable are all set.
// - Writing one clears that flag; writing zero leaves it unchanged.
// - Register writes never set a status flag.
// - Hardware never clears a flag itself.
// - Status is 32 bits at offset 0Ch, resetting to all zeros.
// - Owner change flag bit 30 sets when owner change request bit 3 sets.
// - Unmasked owner change immediately raises the system management request.
// - Without the system management pin, owner change flag stays zero.
// - Root hub change flag bit 6 sets on any root hub or port state change.
// - Frame overflow flag bit 5 sets on the first shared frame update after frame counter bit 15 toggles.
// - Fatal error flag bit 4 sets on system error; processing then halts.
// - Resume flag bit 3 sets on device resume onset, not on software resume.
// - Frame start flag bit 2 sets at each frame start outside fatal halt, with the SOF token.
// - Done head flag bit 1 sets right after the done pointer writeback.
// - While done head flag is set, no further done pointer writeback.
// - Overrun flag bit 0 sets when the frame schedule overruns.
// - Every overrun increments the two-bit overrun count.
// - Overrun count starts at zero, wraps, and counts with flag already set.
// - Enable register: write one sets, write zero keeps; reads return value.
`timescale 1ns/1ps
`include "hevs_regs.vh"
module hevs_status #(
	parameter HAS_SMI_PIN = 1,
	parameter NUM_PORTS = 2
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Register access from the bus target
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	// Enable clear path, driven by the companion disable register
	input wire [31:0] enable_clear,
	// Controller events, same clock
	input wire owner_change_request,
	input wire [31:0] root_hub_state,
	input wire [32*NUM_PORTS-1:0] root_port_state,
	input wire [15:0] frame_counter,
	input wire shared_frame_updated,
	input wire system_error,
	input wire frame_start,
	input wire done_head_written,
	input wire schedule_overrun,
	// Resume signaling from the port pins, asynchronous
	input wire bus_resume_pin,
	input wire bus_resume_state,
	// Outputs to the controller
	output wire done_write_allowed,
	output reg fatal_halt,
	output reg [1:0] overrun_count,
	output reg frame_start_token,
	// Interrupt requests
	output wire host_irq,
	output wire sys_mgmt_irq_n
);
	reg [31:0] status_reg;
	reg [31:0] status_next;
	reg [31:0] enable_reg;
	reg [31:0] enable_next;
	reg ocr_prev_reg;
	reg [31:0] hub_prev_reg;
	reg [32*NUM_PORTS-1:0] port_prev_reg;
	reg frame_msb_reg;
	reg frame_ovf_pend_reg;
	reg resume_prev_reg;
	wire resume_sync;
	wire [31:0] event_set;
	wire [31:0] active;
	wire status_wr;
	wire enable_wr;

	// Decode used by both write paths and the read mux
	function hit;
		input [7:0] addr;
		input [7:0] offset;
		begin
			hit = (addr == offset);
		end
	endfunction

	hevs_sync #(
		.WIDTH(1)
	) u_resume_sync (
		.clk(clk),
		.rst(rst),
		.d(bus_resume_pin),
		.q(resume_sync)
	);

	assign status_wr = reg_wr && hit(reg_addr, `HEVS_STATUS_OFFSET);
	assign enable_wr = reg_wr && hit(reg_addr, `HEVS_ENABLE_OFFSET);

	// Frame overflow waits until the shared frame number copy is refreshed
	wire frame_toggle;
	assign frame_toggle = frame_counter[`HEVS_FRAME_MSB] != frame_msb_reg;

	// Event detection; each flag is set only by its event
	assign event_set[`HEVS_BIT_OWNER] = (HAS_SMI_PIN != 0)
		&& owner_change_request && !ocr_prev_reg;
	assign event_set[`HEVS_BIT_ROOT_HUB] = (root_hub_state != hub_prev_reg)
		|| (root_port_state != port_prev_reg);
	assign event_set[`HEVS_BIT_FRAME_OVF] = shared_frame_updated
		&& (frame_ovf_pend_reg || frame_toggle);
	assign event_set[`HEVS_BIT_FATAL] = system_error;
	// Software-entered resume is excluded by gating on the resume state
	assign event_set[`HEVS_BIT_RESUME] = resume_sync && !resume_prev_reg
		&& !bus_resume_state;
	assign event_set[`HEVS_BIT_FRAME_START] = frame_start && !fatal_halt;
	assign event_set[`HEVS_BIT_DONE_HEAD] = done_head_written && done_write_allowed;
	assign event_set[`HEVS_BIT_OVERRUN] = schedule_overrun;
	assign event_set[29:7] = 23'h000000;
	assign event_set[31] = 1'b0;

	// Writeback is held off while the done head flag is still set or processing is halted
	assign done_write_allowed = !status_reg[`HEVS_BIT_DONE_HEAD] && !fatal_halt;

	always @*
	begin
		status_next = status_reg;
		if (status_wr)
			status_next = status_next & ~reg_wdata;
		// Set after clear so a same-cycle event is never lost
		status_next = (status_next | event_set) & `HEVS_STATUS_MASK;
		if (HAS_SMI_PIN == 0)
			status_next[`HEVS_BIT_OWNER] = 1'b0;
	end

	always @*
	begin
		enable_next = enable_reg & ~enable_clear;
		if (enable_wr)
			enable_next = enable_next | reg_wdata;
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			status_reg <= `HEVS_STATUS_RESET;
			enable_reg <= `HEVS_ENABLE_RESET;
			ocr_prev_reg <= 1'b0;
			hub_prev_reg <= 32'h00000000;
			port_prev_reg <= {32*NUM_PORTS{1'b0}};
			frame_msb_reg <= 1'b0;
			frame_ovf_pend_reg <= 1'b0;
			resume_prev_reg <= 1'b0;
			fatal_halt <= 1'b0;
			overrun_count <= 2'h0;
			frame_start_token <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			ocr_prev_reg <= owner_change_request;
			hub_prev_reg <= root_hub_state;
			port_prev_reg <= root_port_state;
			frame_msb_reg <= frame_counter[`HEVS_FRAME_MSB];
			if (shared_frame_updated)
				frame_ovf_pend_reg <= 1'b0;
			else if (frame_toggle)
				frame_ovf_pend_reg <= 1'b1;
			resume_prev_reg <= resume_sync;
			// Halt stays until software clears the error flag after reset
			fatal_halt <= status_next[`HEVS_BIT_FATAL];
			if (schedule_overrun)
				overrun_count <= overrun_count + 2'h1;
			frame_start_token <= event_set[`HEVS_BIT_FRAME_START];
		end
	end

	assign active = status_reg & enable_reg;

	// Level request, master enable gates all but the owner change path
	assign host_irq = enable_reg[`HEVS_BIT_MASTER]
		&& (|active[`HEVS_BIT_ROOT_HUB:`HEVS_BIT_OVERRUN]);
	// Owner change goes straight out regardless of master enable
	assign sys_mgmt_irq_n = !((HAS_SMI_PIN != 0) && active[`HEVS_BIT_OWNER]);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			if (hit(reg_addr, `HEVS_STATUS_OFFSET))
				reg_rdata <= status_reg;
			else if (hit(reg_addr, `HEVS_ENABLE_OFFSET))
				reg_rdata <= enable_reg;
			else
				reg_rdata <= 32'h00000000;
		end
	end
endmodule

// ### bench/hevs_props.sv
// Port checks of the host event status block
`timescale 1ns/1ps
`include "hevs_regs.vh"
module hevs_props (
	input wire clk, input wire rst,
	input wire [7:0] reg_addr, input wire reg_wr, input wire [31:0] reg_wdata,
	input wire system_error, input wire frame_start, input wire done_head_written,
	input wire schedule_overrun, input wire done_write_allowed, input wire fatal_halt,
	input wire [1:0] overrun_count, input wire frame_start_token
);
	wire w1c = reg_wr && reg_addr == `HEVS_STATUS_OFFSET;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_fat; system_error |=> fatal_halt; endproperty
	a_fat: assert property (p_fat) else $error("fatal flag not set");
	property p_keep; fatal_halt && !(w1c && reg_wdata[4]) |=> fatal_halt; endproperty
	a_keep: assert property (p_keep) else $error("fatal flag dropped");
	property p_cnt; schedule_overrun |=> overrun_count == $past(overrun_count) + 2'h1; endproperty
	a_cnt: assert property (p_cnt) else $error("overrun count step");
	property p_hold; !schedule_overrun |=> $stable(overrun_count); endproperty
	a_hold: assert property (p_hold) else $error("overrun count moved");
	property p_done; done_head_written && done_write_allowed |=> !done_write_allowed; endproperty
	a_done: assert property (p_done) else $error("done flag not set");
	property p_blk; !done_write_allowed && !(w1c && reg_wdata[1]) |=> !done_write_allowed; endproperty
	a_blk: assert property (p_blk) else $error("done pointer write reopened");
	property p_clr; w1c && reg_wdata[1] && !done_head_written && !fatal_halt && !system_error
		|=> done_write_allowed; endproperty
	a_clr: assert property (p_clr) else $error("done flag not cleared");
	property p_sof; frame_start && !fatal_halt |=> frame_start_token; endproperty
	a_sof: assert property (p_sof) else $error("frame token missing");
endmodule
bind hevs_status hevs_props hevs_props_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_wdata(reg_wdata), .system_error(system_error),
	.frame_start(frame_start), .done_head_written(done_head_written),
	.schedule_overrun(schedule_overrun), .done_write_allowed(done_write_allowed),
	.fatal_halt(fatal_halt), .overrun_count(overrun_count), .frame_start_token(frame_start_token));

// ### bench/hevs_host.sv
// Driver software model on the register side
`timescale 1ns/1ps
`include "hevs_regs.vh"
module hevs_host (
	input wire clk,
	output reg [7:0] reg_addr, output reg reg_wr, output reg reg_rd,
	output reg [31:0] reg_wdata, input wire [31:0] reg_rdata
);
	initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 42'h0;
	// Fatal flag kept set: it may only be cleared after a controller reset
	task wr(input [7:0] a, input [31:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_wdata = (a == `HEVS_STATUS_OFFSET) ? d & 32'h4000006F : d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	end
	endtask
	task rd(input [7:0] a, output [31:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	end
	endtask
endmodule

// ### bench/testbench.sv
// Self-checking bench for the host event status block
`timescale 1ns/1ps
`include "hevs_regs.vh"
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg [7:0] ev = 8'h00;
	reg [31:0] rhs = 32'h0;
	reg [15:0] fc = 16'h0;
	reg brs = 1'b0;
	wire [7:0] a;
	wire wr, rd, hirq, smi_n;
	wire [31:0] wd, rdat;
	wire [1:0] cnt_o;
	integer st = 0, cnt = 0, mismatches = 0, checked = 0, i, k;
	reg [31:0] seed = 32'd54, v;
	always #5 clk = ~clk;
	hevs_host hevs_host_inst (.clk(clk), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wd), .reg_rdata(rdat));
	hevs_status hevs_status_inst (.clk(clk), .rst(rst), .reg_addr(a), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wd), .reg_rdata(rdat), .enable_clear(32'h0), .owner_change_request(ev[7]),
		.root_hub_state(rhs), .root_port_state(64'h0), .frame_counter(fc),
		.shared_frame_updated(ev[5]), .system_error(ev[4]), .frame_start(ev[2]),
		.done_head_written(ev[1]), .schedule_overrun(ev[0]), .bus_resume_pin(ev[3]),
		.bus_resume_state(brs), .done_write_allowed(), .fatal_halt(), .overrun_count(cnt_o),
		.frame_start_token(), .host_irq(hirq), .sys_mgmt_irq_n(smi_n));
	function [31:0] xs(input [31:0] x);
	begin
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	end
	endfunction
	task chk(input [31:0] g, input [31:0] e);
	begin
		checked = checked + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task look;
	begin
		hevs_host_inst.rd(`HEVS_STATUS_OFFSET, v);
		chk(v, st);
		chk(hirq, (st & 32'h7F) != 0);
		chk(smi_n, !st[30]);
		chk(cnt_o, cnt % 4);
	end
	endtask
	// Each event held for one cycle, then time for the resume synchroniser
	task fire(input integer n);
	begin
		@(negedge clk);
		ev[n] = 1'b1;
		if (n == 5) fc = fc ^ 16'h8000;
		if (n == 6) rhs = rhs + 1;
		@(negedge clk);
		ev = 8'h00;
		repeat (4) @(negedge clk);
		if (!((n == 1 && (st[1] || st[4])) || (n == 2 && st[4]))) st = st | (1 << (n == 7 ? 30 : n));
		if (n == 0) cnt = cnt + 1;
		look;
	end
	endtask
	task test_done;
	begin
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		look;
		hevs_host_inst.rd(8'h44, v);
		chk(v, 0);
		hevs_host_inst.wr(`HEVS_ENABLE_OFFSET, 32'hC000007F);
		hevs_host_inst.wr(`HEVS_ENABLE_OFFSET, 32'h0);
		hevs_host_inst.rd(`HEVS_ENABLE_OFFSET, v);
		chk(v, 32'hC000007F);
		for (i = 0; i < 48; i = i + 1)
		begin
			seed = xs(seed);
			k = (seed[2:0] == 3'h4) ? 7 : seed[2:0];
			fire(k);
			seed = xs(seed);
			hevs_host_inst.wr(`HEVS_STATUS_OFFSET, seed | 32'h10);
			st = st & ~(seed & 32'h4000006F);
			look;
		end
		// Resume seen while software holds the resume state must not flag
		hevs_host_inst.wr(`HEVS_STATUS_OFFSET, 32'h8);
		st = st & ~32'h8;
		@(negedge clk);
		brs = 1'b1;
		ev[3] = 1'b1;
		@(negedge clk);
		ev = 8'h00;
		repeat (4) @(negedge clk);
		brs = 1'b0;
		look;
		fire(4);
		fire(2);
		fire(1);
		test_done;
	end
endmodule
